//--- logic/nsu_pkg.sv
package nsu_pkg;

  // Timebase: one program cycle every 5 ms at a 50 MHz clock
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_MS     = 5;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Sizes
  localparam int unsigned NGROUPS = 8;
  localparam int unsigned NREC    = 12;

  // Scaling: currents in 0.01 In, sequence ratios in 0.01 %, measured/set ratio in 1 %
  localparam logic [31:0] RATIO_PCT_SCALE = 32'h0000_2710;
  localparam logic [31:0] RATIO_UNIT      = 32'h0000_0064;
  localparam logic [39:0] PCT_FULL        = 40'h00_0000_0064;
  localparam logic [39:0] PCT_RESET       = 40'h00_0000_0061;
  localparam logic [30:0] SIN60_Q10       = 31'h0000_0377;
  localparam logic [30:0] THIRD_Q10       = 31'h0000_0155;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_OPDLY    = 8'h04;
  localparam logic [7:0] OFF_CURVE_K  = 8'h08;
  localparam logic [7:0] OFF_RELDLY   = 8'h0c;
  localparam logic [7:0] OFF_MINLOAD  = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_SEQRATIO = 8'h18;
  localparam logic [7:0] OFF_SETRATIO = 8'h1c;
  localparam logic [7:0] OFF_REMAIN   = 8'h20;
  localparam logic [7:0] OFF_SEQMAG   = 8'h24;
  localparam logic [7:0] OFF_RECSEL   = 8'h28;
  localparam logic [7:0] OFF_RECTIME  = 8'h2c;
  localparam logic [7:0] OFF_RECMAG   = 8'h30;
  localparam logic [7:0] OFF_RECZERO  = 8'h34;
  localparam logic [7:0] OFF_RECANG   = 8'h38;
  localparam logic [7:0] OFF_RECKIND  = 8'h3c;
  localparam logic [2:0] WIN_NSP      = 3'h2;
  localparam logic [2:0] WIN_RAT      = 3'h3;

  // Control register fields
  localparam int unsigned CTRL_MODE   = 0;
  localparam int unsigned CTRL_FORCE  = 1;
  localparam int unsigned CTRL_FORCED = 2;
  localparam int unsigned CTRL_GROUP  = 4;
  localparam int unsigned CTRL_DLY    = 7;

  // Reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] OPDLY_RST   = 32'h0000_0014;
  localparam logic [31:0] CURVE_K_RST = 32'h0001_0000;
  localparam logic [31:0] RELDLY_RST  = 32'h0000_0000;
  localparam logic [31:0] MINLOAD_RST = 32'h0000_000a;
  localparam logic [15:0] NSP_RST     = 16'h0014;
  localparam logic [15:0] RAT_RST     = 16'h07d0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    COND_NORMAL  = 2'b00,
    COND_START   = 2'b01,
    COND_TRIP    = 2'b10,
    COND_BLOCKED = 2'b11
  } nsu_cond_e;

  typedef enum logic [1:0] {
    DLY_INSTANT = 2'b00,
    DLY_DEFINITE = 2'b01,
    DLY_INVERSE = 2'b10
  } nsu_dly_e;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_LOAD  = 3'b001,
    SEQ_RATIO = 3'b010,
    SEQ_SETR  = 3'b011,
    SEQ_EVAL  = 3'b100,
    SEQ_REM   = 3'b101
  } nsu_seq_e;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } nsu_phasor_s;

  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0]  kind;
    logic [15:0] i1;
    logic [15:0] i2;
    logic [15:0] iz;
    logic [15:0] ang_p;
    logic [15:0] ang_n;
    logic [15:0] ang_z;
    logic [15:0] remain;
  } nsu_rec_s;

endpackage : nsu_pkg

//--- logic/nsu_unbalance_stage.sv
// Summary of operation
// - Supervise negative magnitude or sequence ratio
// - Derive sequence magnitudes from phase currents
// - Refresh and evaluate every 5 ms
// - Ratio mode checks phase fundamental loading
// - Pick up when quantity exceeds setting
// - Release below 97 % of setting
// - Magnitude setting in 0.01 In, default 0.2
// - Ratio setting in 0.01 %, default 20 %
// - Pick-up settings follow live setting group
// - Forced state override behind global enable
// - Mode and forcing ignore setting group
// - Sample block input each cycle first
// - Pick-up without block gives start, or trip at once when timing is instant
// - Pick-up with block gives blocked only
// - Late block drops start, runs release
// - Publish condition as four codes
// - Publish measured/set and sequence ratios
// - Publish remaining time to trip
// - Zero sequence and angles only recorded
// - Instant, definite or inverse trip timing
// - Keep twelve latest time-stamped records
//
// The register offsets and the AXI4-Lite register port were decided locally.
module nsu_unbalance_stage #(
  parameter int unsigned TICK_CYCLES = nsu_pkg::TICK_CYCLES,
  parameter int unsigned NREC        = nsu_pkg::NREC
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]          awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic [2:0]          arprot,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // Phase current phasors and fundamentals, 0.01 In
  input  nsu_pkg::nsu_phasor_s     phase_a,
  input  nsu_pkg::nsu_phasor_s     phase_b,
  input  nsu_pkg::nsu_phasor_s     phase_c,
  input  wire logic [15:0]         phase_a_rms,
  input  wire logic [15:0]         phase_b_rms,
  input  wire logic [15:0]         phase_c_rms,
  // Sequence angles, 0.01 deg
  input  wire logic [15:0]         pos_seq_angle,
  input  wire logic [15:0]         neg_seq_angle,
  input  wire logic [15:0]         zero_seq_angle,
  // Blocking matrix
  input  wire logic                block_in,
  // Stage outputs
  output logic                     start_out,
  output logic                     trip_out,
  output logic                     blocked_out,
  output logic [1:0]               condition
);

  localparam int unsigned RW = $clog2(NREC);

  // Magnitude of a complex sum, divided by three; max/min estimate within 3 %
  function automatic logic [15:0] mag3(input logic signed [19:0] re, input logic signed [19:0] im);
    logic [19:0] ar;
    logic [19:0] ai;
    logic [19:0] mx;
    logic [19:0] mn;
    logic [20:0] m;
    logic [30:0] s;
    ar = re[19] ? 20'(-re) : 20'(re);
    ai = im[19] ? 20'(-im) : 20'(im);
    mx = (ar > ai) ? ar : ai;
    mn = (ar > ai) ? ai : ar;
    m  = 21'(mx) - 21'(mx >> 3) + 21'(mn >> 1);
    if (m < 21'(mx)) m = 21'(mx);
    s = (31'(m) * nsu_pkg::THIRD_Q10) >> 10;
    return (s > 31'h0000_ffff) ? 16'hffff : s[15:0];
  endfunction : mag3

  // Program-cycle tick
  logic [31:0] tick_cnt;
  logic        tick;
  logic [31:0] stamp;
  wire         tick_wrap = (tick_cnt == 32'(TICK_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
      stamp    <= 32'h0;
    end else begin
      tick_cnt <= tick_wrap ? 32'h0 : tick_cnt + 32'h1;
      tick     <= tick_wrap;
      stamp    <= stamp + {31'h0, tick_wrap};
    end
  end

  // Software registers
  logic [31:0] ctrl;
  logic [31:0] op_delay;
  logic [31:0] curve_k;
  logic [31:0] rel_delay;
  logic [31:0] min_load;
  logic [31:0] rec_sel;
  logic [15:0] nsp_lvl [nsu_pkg::NGROUPS];
  logic [15:0] rat_lvl [nsu_pkg::NGROUPS];

  // Static fields; the group only indexes the pick-up tables
  wire       mode_ratio = ctrl[nsu_pkg::CTRL_MODE];
  wire       force_en   = ctrl[nsu_pkg::CTRL_FORCE];
  wire [1:0] forced     = ctrl[nsu_pkg::CTRL_FORCED +: 2];
  wire [2:0] grp        = ctrl[nsu_pkg::CTRL_GROUP +: 3];
  wire [1:0] dly        = ctrl[nsu_pkg::CTRL_DLY +: 2];

  // Symmetrical components from the phase phasors
  wire signed [19:0] p_re  = 20'(phase_a.re) - ((20'(phase_b.re) + 20'(phase_c.re)) >>> 1);
  wire signed [19:0] p_im  = 20'(phase_a.im) - ((20'(phase_b.im) + 20'(phase_c.im)) >>> 1);
  wire signed [30:0] r_re  = 31'(20'(phase_b.im) - 20'(phase_c.im)) * $signed(nsu_pkg::SIN60_Q10);
  wire signed [30:0] r_im  = 31'(20'(phase_c.re) - 20'(phase_b.re)) * $signed(nsu_pkg::SIN60_Q10);
  wire signed [19:0] u_re  = 20'(r_re >>> 10);
  wire signed [19:0] u_im  = 20'(r_im >>> 10);
  wire signed [19:0] z_re  = 20'(phase_a.re) + 20'(phase_b.re) + 20'(phase_c.re);
  wire signed [19:0] z_im  = 20'(phase_a.im) + 20'(phase_b.im) + 20'(phase_c.im);
  wire [15:0]        i1_now = mag3(p_re - u_re, p_im - u_im);
  wire [15:0]        i2_now = mag3(p_re + u_re, p_im + u_im);
  wire [15:0]        iz_now = mag3(z_re, z_im);
  wire               load_now = (phase_a_rms >= min_load[15:0]) ||
                                (phase_b_rms >= min_load[15:0]) ||
                                (phase_c_rms >= min_load[15:0]);

  // Snapshot taken at the start of each program cycle
  logic [15:0] i1_q, i2_q, iz_q, angp_q, angn_q, angz_q;
  logic        blk_q, load_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {i1_q, i2_q, iz_q, angp_q, angn_q, angz_q} <= '0;
      blk_q  <= 1'b0;
      load_q <= 1'b0;
    end else if (tick) begin
      {i1_q, i2_q, iz_q} <= {i1_now, i2_now, iz_now};
      {angp_q, angn_q, angz_q} <= {pos_seq_angle, neg_seq_angle, zero_seq_angle};
      blk_q  <= block_in;
      load_q <= load_now;
    end
  end

  // Serial divider shared by three quotients; a zero divisor gives all ones
  nsu_pkg::nsu_seq_e seq;
  logic [31:0] div_n, div_d, div_q;
  logic [32:0] div_r;
  logic [5:0]  div_cnt;
  logic [23:0] seq_ratio;
  logic [31:0] set_ratio;
  wire  [32:0] div_try  = {div_r[31:0], div_n[31]};
  wire         div_fit  = (div_try >= {1'b0, div_d});
  wire         div_done = (div_cnt == 6'h20);
  wire  [23:0] q_sat    = (|div_q[31:24]) ? 24'hffffff : div_q[23:0];

  // Evaluation operands; group selection is live
  wire [31:0] meas     = mode_ratio ? {8'h0, seq_ratio} : {16'h0, i2_q};
  wire [31:0] meas_div = mode_ratio ? {8'h0, q_sat} : {16'h0, i2_q};
  wire [15:0] setv     = mode_ratio ? rat_lvl[grp] : nsp_lvl[grp];
  wire        above    = meas > {16'h0, setv};
  wire        below    = (40'(meas) * nsu_pkg::PCT_FULL) <
                         (40'(setv) * nsu_pkg::PCT_RESET);
  wire        load_ok  = !mode_ratio || load_q;
  logic       pickup;
  wire        next_pickup = pickup ? (!below && load_ok) : (above && load_ok);
  wire        running  = next_pickup && !blk_q;

  // Inverse timing integrates m^2 - s^2 per cycle against k
  wire [15:0] m16      = (|meas[31:16]) ? 16'hffff : meas[15:0];
  wire [31:0] msq      = 32'(m16) * 32'(m16);
  wire [31:0] ssq      = 32'(setv) * 32'(setv);
  wire [31:0] rate     = (msq > ssq) ? msq - ssq : 32'h0;
  logic [31:0] acc, dt_cnt, rel_cnt, remain;
  wire [32:0] acc_sum  = 33'(acc) + 33'(rate);
  wire [31:0] acc_next = acc_sum[32] ? 32'hffffffff : acc_sum[31:0];
  wire [31:0] dt_next  = (&dt_cnt) ? dt_cnt : dt_cnt + 32'h1;
  wire        is_inv   = (dly == nsu_pkg::DLY_INVERSE);
  wire        trip_now = (dly == nsu_pkg::DLY_INSTANT) ||
                         (is_inv && acc_next >= curve_k) ||
                         (!is_inv && dly != nsu_pkg::DLY_INSTANT && dt_next >= op_delay);

  // Sequencer: snapshot, two ratios, evaluation, inverse remaining time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq       <= nsu_pkg::SEQ_IDLE;
      {div_n, div_d, div_q, div_r, div_cnt} <= '0;
      seq_ratio <= 24'h0;
      set_ratio <= 32'h0;
    end else begin
      if (!div_done) begin
        div_r   <= div_fit ? div_try - {1'b0, div_d} : div_try;
        div_n   <= div_n << 1;
        div_q   <= {div_q[30:0], div_fit};
        div_cnt <= div_cnt + 6'h1;
      end
      unique case (seq)
        nsu_pkg::SEQ_IDLE: if (tick) seq <= nsu_pkg::SEQ_LOAD;
        nsu_pkg::SEQ_LOAD: begin
          {div_n, div_d} <= {32'(i2_q) * nsu_pkg::RATIO_PCT_SCALE, 16'h0, i1_q};
          {div_r, div_q, div_cnt} <= '0;
          seq <= nsu_pkg::SEQ_RATIO;
        end
        nsu_pkg::SEQ_RATIO: if (div_done) begin
          seq_ratio <= q_sat;
          {div_n, div_d} <= {32'(meas_div * nsu_pkg::RATIO_UNIT), 16'h0, setv};
          {div_r, div_q, div_cnt} <= '0;
          seq <= nsu_pkg::SEQ_SETR;
        end
        nsu_pkg::SEQ_SETR: if (div_done) begin
          set_ratio <= div_q;
          seq <= nsu_pkg::SEQ_EVAL;
        end
        nsu_pkg::SEQ_EVAL: begin
          {div_n, div_d} <= {curve_k - acc_next, rate};
          {div_r, div_q, div_cnt} <= '0;
          seq <= nsu_pkg::SEQ_REM;
        end
        nsu_pkg::SEQ_REM: if (div_done) seq <= nsu_pkg::SEQ_IDLE;
        default: seq <= nsu_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Protection state, updated once per program cycle
  nsu_pkg::nsu_cond_e cond;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond    <= nsu_pkg::COND_NORMAL;
      pickup  <= 1'b0;
      {acc, dt_cnt, rel_cnt, remain} <= '0;
    end else if (seq == nsu_pkg::SEQ_EVAL) begin
      pickup <= next_pickup;
      if (running) begin
        rel_cnt <= rel_delay;
        acc     <= acc_next;
        dt_cnt  <= dt_next;
        cond    <= trip_now ? nsu_pkg::COND_TRIP : nsu_pkg::COND_START;
        remain  <= (trip_now || is_inv) ? 32'h0 : op_delay - dt_next;
      end else begin
        cond   <= next_pickup ? nsu_pkg::COND_BLOCKED : nsu_pkg::COND_NORMAL;
        remain <= 32'h0;
        if (rel_cnt != 32'h0) begin
          rel_cnt <= rel_cnt - 32'h1;
        end else begin
          acc    <= 32'h0;
          dt_cnt <= 32'h0;
        end
      end
    end else if (seq == nsu_pkg::SEQ_REM && div_done && is_inv && cond == nsu_pkg::COND_START) begin
      remain <= div_q;
    end
  end

  // Published condition, forced when stage forcing is enabled
  wire [1:0] disp = force_en ? forced : cond;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      condition   <= nsu_pkg::COND_NORMAL;
      start_out   <= 1'b0;
      trip_out    <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      condition   <= disp;
      start_out   <= (disp == nsu_pkg::COND_START);
      trip_out    <= (disp == nsu_pkg::COND_TRIP);
      blocked_out <= (disp == nsu_pkg::COND_BLOCKED);
    end
  end

  // Fault records: each entry into start, trip or blocked overwrites the oldest
  nsu_pkg::nsu_rec_s recs [NREC];
  logic [RW-1:0] wptr;
  logic [RW:0]   rec_count;
  wire           rec_fire = (disp != condition) && (disp != nsu_pkg::COND_NORMAL);
  wire [RW-1:0]  sel_c    = (rec_sel >= 32'(NREC)) ? RW'(NREC - 1) : rec_sel[RW-1:0];
  wire [RW:0]    back     = (RW+1)'(wptr) + (RW+1)'(NREC - 1) - (RW+1)'(sel_c);
  wire [RW:0]    slot     = (back >= (RW+1)'(NREC)) ? back - (RW+1)'(NREC) : back;
  wire nsu_pkg::nsu_rec_s rec_rd = recs[slot[RW-1:0]];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NREC; i++) recs[i] <= '0;
      wptr      <= '0;
      rec_count <= '0;
    end else if (rec_fire) begin
      recs[wptr] <= {stamp, disp, i1_q, i2_q, iz_q, angp_q, angn_q, angz_q,
                     (|remain[31:16]) ? 16'hffff : remain[15:0]};
      wptr       <= (wptr == RW'(NREC - 1)) ? '0 : wptr + RW'(1);
      if (rec_count != (RW+1)'(NREC)) rec_count <= rec_count + (RW+1)'(1);
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  wire         wr_go  = !awready && !wready && !bvalid;
  wire [31:0]  bmask  = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  wire         wr_win = (aw_q[7:5] == nsu_pkg::WIN_NSP) || (aw_q[7:5] == nsu_pkg::WIN_RAT);
  wire         wr_hit = wr_win || (aw_q <= nsu_pkg::OFF_MINLOAD) || (aw_q == nsu_pkg::OFF_RECSEL);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= nsu_pkg::RESP_OKAY;
      {aw_q, wd_q, ws_q} <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_q    <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        {wd_q, ws_q} <= {wdata, wstrb};
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? nsu_pkg::RESP_OKAY : nsu_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        {bvalid, awready, wready} <= 3'b011;
      end
    end
  end

  // Register writes honour the byte strobes
  wire [31:0] old_w = wr_win ? 32'(aw_q[5] ? rat_lvl[aw_q[4:2]] : nsp_lvl[aw_q[4:2]]) : 32'h0;
  wire [31:0] new_w = (wd_q & bmask) | (old_w & ~bmask);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl      <= nsu_pkg::CTRL_RST;
      op_delay  <= nsu_pkg::OPDLY_RST;
      curve_k   <= nsu_pkg::CURVE_K_RST;
      rel_delay <= nsu_pkg::RELDLY_RST;
      min_load  <= nsu_pkg::MINLOAD_RST;
      rec_sel   <= 32'h0;
      for (int g = 0; g < nsu_pkg::NGROUPS; g++) begin
        nsp_lvl[g] <= nsu_pkg::NSP_RST;
        rat_lvl[g] <= nsu_pkg::RAT_RST;
      end
    end else if (wr_go) begin
      unique case (aw_q)
        nsu_pkg::OFF_CTRL:    ctrl      <= (wd_q & bmask) | (ctrl & ~bmask);
        nsu_pkg::OFF_OPDLY:   op_delay  <= (wd_q & bmask) | (op_delay & ~bmask);
        nsu_pkg::OFF_CURVE_K: curve_k   <= (wd_q & bmask) | (curve_k & ~bmask);
        nsu_pkg::OFF_RELDLY:  rel_delay <= (wd_q & bmask) | (rel_delay & ~bmask);
        nsu_pkg::OFF_MINLOAD: min_load  <= (wd_q & bmask) | (min_load & ~bmask);
        nsu_pkg::OFF_RECSEL:  rec_sel   <= (wd_q & bmask) | (rec_sel & ~bmask);
        default: begin
          if (aw_q[7:5] == nsu_pkg::WIN_NSP) nsp_lvl[aw_q[4:2]] <= new_w[15:0];
          if (aw_q[7:5] == nsu_pkg::WIN_RAT) rat_lvl[aw_q[4:2]] <= new_w[15:0];
        end
      endcase
    end
  end

  // Read decode
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    unique case (araddr)
      nsu_pkg::OFF_CTRL:     rd_word = ctrl;
      nsu_pkg::OFF_OPDLY:    rd_word = op_delay;
      nsu_pkg::OFF_CURVE_K:  rd_word = curve_k;
      nsu_pkg::OFF_RELDLY:   rd_word = rel_delay;
      nsu_pkg::OFF_MINLOAD:  rd_word = min_load;
      nsu_pkg::OFF_STATUS:   rd_word = {24'h0, 4'(rec_count), blk_q, pickup, condition};
      nsu_pkg::OFF_SEQRATIO: rd_word = {8'h0, seq_ratio};
      nsu_pkg::OFF_SETRATIO: rd_word = set_ratio;
      nsu_pkg::OFF_REMAIN:   rd_word = remain;
      nsu_pkg::OFF_SEQMAG:   rd_word = {i2_q, i1_q};
      nsu_pkg::OFF_RECSEL:   rd_word = rec_sel;
      nsu_pkg::OFF_RECTIME:  rd_word = rec_rd.stamp;
      nsu_pkg::OFF_RECMAG:   rd_word = {rec_rd.i2, rec_rd.i1};
      nsu_pkg::OFF_RECZERO:  rd_word = {rec_rd.remain, rec_rd.iz};
      nsu_pkg::OFF_RECANG:   rd_word = {rec_rd.ang_n, rec_rd.ang_p};
      nsu_pkg::OFF_RECKIND:  rd_word = {14'h0, rec_rd.kind, rec_rd.ang_z};
      default: begin
        rd_hit  = (araddr[7:5] == nsu_pkg::WIN_NSP) || (araddr[7:5] == nsu_pkg::WIN_RAT);
        rd_word = !rd_hit ? 32'h0 : araddr[5] ? {16'h0, rat_lvl[araddr[4:2]]}
                                              : {16'h0, nsp_lvl[araddr[4:2]]};
      end
    endcase
  end

  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= nsu_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_hit ? nsu_pkg::RESP_OKAY : nsu_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : nsu_unbalance_stage

//--- test/nsu_chan_model.sv
module nsu_chan_model (
  // Clock
  input  logic                 aclk,
  // Sequence levels and block asked for by the bench, 0.01 In
  input  logic [15:0]          i1_lvl,
  input  logic [15:0]          i2_lvl,
  input  logic                 blk,
  // Measurement channels and blocking matrix
  output nsu_pkg::nsu_phasor_s phase_a,
  output nsu_pkg::nsu_phasor_s phase_b,
  output nsu_pkg::nsu_phasor_s phase_c,
  output logic [15:0]          phase_a_rms,
  output logic [15:0]          phase_b_rms,
  output logic [15:0]          phase_c_rms,
  output logic [15:0]          pos_seq_angle,
  output logic [15:0]          neg_seq_angle,
  output logic [15:0]          zero_seq_angle,
  output logic                 block_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int s;
  int d;

  // Positive plus negative balanced sets, phase a on the real axis
  assign s = int'(i1_lvl) + int'(i2_lvl);
  assign d = (int'(i1_lvl) - int'(i2_lvl)) * 866 / 1000;
  assign pos_seq_angle = 16'h0000;
  assign neg_seq_angle = 16'h2ee0;
  assign zero_seq_angle = 16'h0000;

  // Rms is a coarse phase a magnitude; only the loading test uses it
  always_ff @(posedge aclk) begin
    phase_a <= {16'(s), 16'h0000};
    phase_b <= {16'(-s / 2), 16'(-d)};
    phase_c <= {16'(-s / 2), 16'(d)};
    phase_a_rms <= 16'(s);
    phase_b_rms <= 16'(s);
    phase_c_rms <= 16'(s);
    block_in <= blk;
  end
endmodule : nsu_chan_model

//--- test/nsu_stage_monitor.sv
module nsu_stage_monitor (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Bus handshakes
  input logic        awready,
  input logic        wready,
  input logic        bvalid,
  input logic        bready,
  input logic        arvalid,
  input logic        arready,
  input logic        rvalid,
  input logic        rready,
  input logic [31:0] rdata,
  // Stage outputs
  input logic        start_out,
  input logic        trip_out,
  input logic        blocked_out,
  input logic [1:0]  condition
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Output flags are a one-hot view of the published code
  AST_START_FLAG: assert property (start_out == (condition == 2'h1))
    else $error("start flag disagrees with condition");
  AST_TRIP_FLAG: assert property (trip_out == (condition == 2'h2))
    else $error("trip flag disagrees with condition");
  AST_BLK_FLAG: assert property (blocked_out == (condition == 2'h3))
    else $error("blocked flag disagrees with condition");
  // Read answer comes one cycle after the take and stands until accepted
  AST_RD_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("read answer not one cycle after address");
  AST_RD_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped or changed early");
  AST_RD_BUSY: assert property (rvalid |-> !arready)
    else $error("read address accepted while answer pending");
  // A second write must stall until the response is taken
  AST_WR_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  AST_WR_BUSY: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  AST_RST_IDLE: assert property ($rose(aresetn) |-> arready && !rvalid && condition == 2'h0)
    else $error("not idle after reset");

  CV_START: cover property ($rose(start_out));
  CV_TRIP: cover property ($rose(trip_out));
  CV_BLOCKED: cover property ($rose(blocked_out));
endmodule : nsu_stage_monitor

bind nsu_unbalance_stage nsu_stage_monitor mon_u (.*);

//--- test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, blk;
  logic                 awready, wready, bvalid, arready, rvalid, block_in;
  logic                 start_out, trip_out, blocked_out;
  logic [7:0]           awaddr, araddr;
  logic [2:0]           awprot, arprot;
  logic [3:0]           wstrb;
  logic [31:0]          wdata, rdata;
  logic [1:0]           bresp, rresp, condition;
  logic [15:0]          i1_lvl, i2_lvl, phase_a_rms, phase_b_rms, phase_c_rms;
  logic [15:0]          pos_seq_angle, neg_seq_angle, zero_seq_angle;
  nsu_pkg::nsu_phasor_s phase_a, phase_b, phase_c;
  int                   n_mismatch, n_compared, k;

  nsu_unbalance_stage #(.TICK_CYCLES(200)) dut_u (.*);
  nsu_chan_model chan_u (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  // Bounded waits: a hang counts as a mismatch and ends the run
  task tmo(input int n);
    if (n >= 900) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : tmo

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 900; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(n);
    chk(bresp, er, "write response");
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 900; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(n);
    chk(rdata, e, "read data");
    chk(rresp, er, "read response");
  endtask : rd

  // Evaluation runs once per tick, so allow several ticks
  task wc(input logic [1:0] e);
    int n;
    for (n = 0; n < 9000 && condition !== e; n++) @(posedge aclk);
    tmo(n / 10);
    chk(condition, e, "condition");
  endtask : wc

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, blk} = '0;
    {awaddr, araddr, awprot, arprot, wdata, i1_lvl, i2_lvl} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h04, nsu_pkg::OPDLY_RST, 2'b00);
    rd(8'h40, 32'h14, 2'b00);
    rd(8'h60, 32'h7d0, 2'b00);
    rd(8'hfc, 32'h0, 2'b10);
    $display("test registers done");
    wr(8'h00, 32'h80, 2'b00);
    i1_lvl <= 16'h0064;
    i2_lvl <= 16'h0028;
    wc(nsu_pkg::COND_START);
    rd(8'h20, 32'h13, 2'b00);
    wc(nsu_pkg::COND_TRIP);
    wr(8'h44, 32'h50, 2'b00);
    wr(8'h00, 32'h90, 2'b00);
    wc(nsu_pkg::COND_NORMAL);
    blk <= 1'b1;
    wr(8'h00, 32'h80, 2'b00);
    wc(nsu_pkg::COND_BLOCKED);
    blk <= 1'b0;
    wc(nsu_pkg::COND_START);
    blk <= 1'b1;
    wc(nsu_pkg::COND_BLOCKED);
    chk(start_out, 32'h0, "start after block");
    blk <= 1'b0;
    i2_lvl <= 16'h0000;
    wc(nsu_pkg::COND_NORMAL);
    $display("test pickup and block done");
    for (k = 0; k < 4; k++) begin
      wr(8'h00, 32'h82 | (k << 2), 2'b00);
      wc(2'(k));
    end
    wr(8'h00, 32'h0c, 2'b00);
    wc(nsu_pkg::COND_NORMAL);
    $display("test forcing done");
    i1_lvl <= 16'h001e;
    i2_lvl <= 16'h000f;
    repeat (600) @(posedge aclk);
    chk(condition, nsu_pkg::COND_NORMAL, "magnitude mode");
    wr(8'h00, 32'h81, 2'b00);
    wc(nsu_pkg::COND_START);
    wr(8'h10, 32'h1f4, 2'b00);
    wc(nsu_pkg::COND_NORMAL);
    rd(8'h14, 32'h90, 2'b00);
    rd(8'h3c, 32'h0001_0000, 2'b00);
    rd(8'h38, 32'h2ee0_0000, 2'b00);
    wr(8'hfc, 32'h1, 2'b10);
    $display("test ratio mode done");
    wr(8'h08, 32'h2000, 2'b00);
    wr(8'h00, 32'h100, 2'b00);
    i2_lvl <= 16'h0028;
    wc(nsu_pkg::COND_START);
    wc(nsu_pkg::COND_TRIP);
    $display("test inverse done");
    wrap_up();
  end
endmodule : tb_top
